/* File: sgl_pkg.sv */
// Shared constants and types for the start guard and edit lock block.
package sgl_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned CLEAR_HOLD_MS = 12;
  localparam int unsigned ALARM_CLEAR_MS = 30;
  localparam int unsigned GUARD_WAIT_S = 3;
  // Least hold time rounds up; it is a whole number of cycles here.
  localparam int unsigned CLEAR_HOLD_CYC = CLEAR_HOLD_MS * CYC_PER_MS;
  localparam int unsigned ALARM_CLEAR_CYC = ALARM_CLEAR_MS * CYC_PER_MS;
  localparam int unsigned STABLE_CYC = 16;
  localparam int unsigned SETTLE_CYC = STABLE_CYC + 8;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FUNC = 8'h08;
  localparam int CTRL_LOCK_SCOPE = 0;
  localparam int CTRL_SW_RESET = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int ST_MOTOR = 0;
  localparam int ST_TRIP = 1;
  localparam int ST_ALARM = 2;
  localparam int ST_TERM_LSB = 4;
  localparam int ST_CODE_LSB = 8;
  localparam int FUNC_GUARD_LSB = 0;
  localparam int FUNC_LOCK_LSB = 8;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FUNC_CODE_START_GUARD = 8'h0d;
  localparam logic [7:0] FUNC_CODE_EDIT_LOCK = 8'h0f;
  localparam logic [7:0] START_GUARD_FAULT_CODE = 8'h0d;
  localparam logic [7:0] NO_FAULT_CODE = 8'h00;

  // Terminal levels, in the order the filter vector uses them.
  typedef struct packed {
    logic fault_clear_input;
    logic edit_lock_input;
    logic start_guard_input;
    logic run_cmd;
  } sgl_term_s;

  // Motor control states.
  typedef enum logic [2:0] {
    SGL_SETTLE = 3'b000,
    SGL_IDLE = 3'b001,
    SGL_RUN = 3'b010,
    SGL_TRIP = 3'b011
  } sgl_state_e;

endpackage

/* File: sgl_level_filter.sv */
// Two-flop synchroniser and stability filter for one terminal level.
`timescale 1ns/10ps
module sgl_level_filter #(
  parameter int unsigned STABLE = 16
) (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic raw, // Terminal level from the pin.
  output logic level // Filtered stable level.
);

  logic meta_q;
  logic sync_q;
  logic level_q;
  logic level_d;
  logic [$clog2(STABLE+1)-1:0] cnt_q;
  logic [$clog2(STABLE+1)-1:0] cnt_d;

  // The new level is taken only after it has stood STABLE cycles.
  always_comb
  begin
    level_d = level_q;
    cnt_d = '0;
    if (sync_q != level_q)
    begin
      cnt_d = cnt_q + 1'b1;
      if (cnt_q == ($clog2(STABLE+1))'(STABLE - 1))
      begin
        level_d = sync_q;
        cnt_d = '0;
      end
    end
  end

  // Only the second flop reads the first.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      level_q <= 1'b0;
      cnt_q <= '0;
    end
    else
    begin
      meta_q <= raw;
      sync_q <= meta_q;
      level_q <= level_d;
      cnt_q <= cnt_d;
    end
  end

  assign level = level_q;

endmodule

/* File: sgl_start_guard_and_edit_lock.sv */
// Start guard and edit lock controller with an APB register slave.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module sgl_start_guard_and_edit_lock #(
  parameter int unsigned CLEAR_HOLD_CYC = sgl_pkg::CLEAR_HOLD_CYC,
  parameter int unsigned STABLE_CYC = sgl_pkg::STABLE_CYC
) (
  input wire logic pclk, // System clock, 100 MHz.
  input wire logic presetn, // Power-up reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB byte strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic run_cmd_raw, // Run command terminal.
  input wire logic start_guard_input_raw, // Start guard terminal.
  input wire logic edit_lock_input_raw, // Edit lock terminal.
  input wire logic fault_clear_input_raw, // Fault clear terminal.
  input wire logic keypad_reset, // Keypad stop/reset key, one-cycle pulse.
  input wire logic edit_req, // Edit request from keypad or remote, pulse.
  input wire logic edit_is_freq, // Edit targets the output frequency.
  output logic edit_grant, // Edit accepted, one-cycle pulse.
  output logic edit_refuse, // Edit refused, one-cycle pulse.
  output logic motor_run, // Motor output drive.
  output logic alarm, // Alarm output.
  output logic [7:0] fault_code // Latched fault code.
);

  // ----------------------------------------------------------------
  // Terminal conditioning
  // ----------------------------------------------------------------
  sgl_pkg::sgl_term_s term_raw;
  sgl_pkg::sgl_term_s term;
  logic [3:0] term_vec;

  assign term_raw = '{fault_clear_input: fault_clear_input_raw,
                      edit_lock_input: edit_lock_input_raw,
                      start_guard_input: start_guard_input_raw,
                      run_cmd: run_cmd_raw};

  // Each terminal gets its own synchroniser and filter.
  for (genvar i = 0; i < 4; i++)
  begin : g_filt
    sgl_level_filter #(
      .STABLE(STABLE_CYC)
    ) u_filt (
      .pclk(pclk),
      .presetn(presetn),
      .raw(term_raw[i]),
      .level(term_vec[i])
    );
  end

  assign term = sgl_pkg::sgl_term_s'(term_vec);

  // ----------------------------------------------------------------
  // Register file and APB slave
  // ----------------------------------------------------------------
  logic lock_scope_q;
  logic lock_scope_d;
  logic sw_reset_q;
  logic sw_reset_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;
  logic pready_q;
  logic setup;
  logic wr_ctrl;
  logic mapped;
  logic [31:0] status_word;
  logic [31:0] func_word;

  sgl_pkg::sgl_state_e st_q;
  sgl_pkg::sgl_state_e st_d;
  logic [7:0] code_q;
  logic [7:0] code_d;

  assign setup = psel && !penable;
  assign mapped = (paddr == sgl_pkg::OFS_CTRL) || (paddr == sgl_pkg::OFS_STATUS) ||
                  (paddr == sgl_pkg::OFS_FUNC);
  assign wr_ctrl = psel && penable && pwrite && pstrb[0] && (paddr == sgl_pkg::OFS_CTRL);

  // Status word shows state, terminal levels and the latched code.
  always_comb
  begin
    status_word = '0;
    status_word[sgl_pkg::ST_MOTOR] = (st_q == sgl_pkg::SGL_RUN);
    status_word[sgl_pkg::ST_TRIP] = (st_q == sgl_pkg::SGL_TRIP);
    status_word[sgl_pkg::ST_ALARM] = (st_q == sgl_pkg::SGL_TRIP);
    status_word[sgl_pkg::ST_TERM_LSB +: 4] = term_vec;
    status_word[sgl_pkg::ST_CODE_LSB +: 8] = code_q;
    func_word = '0;
    func_word[sgl_pkg::FUNC_GUARD_LSB +: 8] = sgl_pkg::FUNC_CODE_START_GUARD;
    func_word[sgl_pkg::FUNC_LOCK_LSB +: 8] = sgl_pkg::FUNC_CODE_EDIT_LOCK;
  end

  // Read data and error are formed in the setup cycle; no wait states.
  always_comb
  begin
    lock_scope_d = lock_scope_q;
    sw_reset_d = 1'b0;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (setup)
    begin
      pslverr_d = !mapped;
      prdata_d = '0;
      if (!pwrite)
      begin
        unique case (paddr)
          sgl_pkg::OFS_CTRL: prdata_d = {31'h0000_0000, lock_scope_q};
          sgl_pkg::OFS_STATUS: prdata_d = status_word;
          sgl_pkg::OFS_FUNC: prdata_d = func_word;
          default: prdata_d = '0;
        endcase
      end
    end
    if (wr_ctrl)
    begin
      lock_scope_d = pwdata[sgl_pkg::CTRL_LOCK_SCOPE];
      sw_reset_d = pwdata[sgl_pkg::CTRL_SW_RESET];
    end
  end

  // Registers of the bus slave.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_scope_q <= sgl_pkg::CTRL_RESET[sgl_pkg::CTRL_LOCK_SCOPE];
      sw_reset_q <= 1'b0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
      pready_q <= 1'b0;
    end
    else
    begin
      lock_scope_q <= lock_scope_d;
      sw_reset_q <= sw_reset_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
      pready_q <= 1'b1;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------
  // Fault clear qualification
  // ----------------------------------------------------------------
  logic [31:0] clr_cnt_q;
  logic [31:0] clr_cnt_d;
  logic clr_accept;
  logic reset_req;

  // A fault clear counts only once held the full minimum time.
  always_comb
  begin
    clr_cnt_d = '0;
    if (term.fault_clear_input)
    begin
      clr_cnt_d = clr_cnt_q;
      if (clr_cnt_q != CLEAR_HOLD_CYC)
      begin
        clr_cnt_d = clr_cnt_q + 32'h0000_0001;
      end
    end
  end

  assign clr_accept = term.fault_clear_input && (clr_cnt_q == CLEAR_HOLD_CYC - 1);
  assign reset_req = clr_accept || keypad_reset || sw_reset_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clr_cnt_q <= '0;
    end
    else
    begin
      clr_cnt_q <= clr_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Start guard state machine
  // ----------------------------------------------------------------
  logic [7:0] settle_q;
  logic [7:0] settle_d;
  logic motor_q;
  logic motor_d;
  logic alarm_q;
  logic alarm_d;

  // Power-up check waits for the filters to settle, then runs, trips or goes idle.
  always_comb
  begin
    st_d = st_q;
    code_d = code_q;
    settle_d = settle_q;
    unique case (st_q)
      sgl_pkg::SGL_SETTLE:
      begin
        settle_d = settle_q + 8'h01;
        if (settle_q == 8'(sgl_pkg::SETTLE_CYC))
        begin
          if (term.run_cmd && term.start_guard_input)
          begin
            st_d = sgl_pkg::SGL_TRIP;
            code_d = sgl_pkg::START_GUARD_FAULT_CODE;
          end
          else if (term.run_cmd)
          begin
            st_d = sgl_pkg::SGL_RUN;
          end
          else
          begin
            st_d = sgl_pkg::SGL_IDLE;
          end
        end
      end
      sgl_pkg::SGL_IDLE:
      begin
        if (term.run_cmd)
        begin
          st_d = sgl_pkg::SGL_RUN;
        end
      end
      sgl_pkg::SGL_RUN:
      begin
        if (!term.run_cmd)
        begin
          st_d = sgl_pkg::SGL_IDLE;
        end
      end
      sgl_pkg::SGL_TRIP:
      begin
        if (!term.run_cmd)
        begin
          st_d = sgl_pkg::SGL_IDLE;
          code_d = sgl_pkg::NO_FAULT_CODE;
        end
        else if (reset_req)
        begin
          st_d = sgl_pkg::SGL_RUN;
          code_d = sgl_pkg::NO_FAULT_CODE;
        end
      end
      default:
      begin
        st_d = sgl_pkg::SGL_IDLE;
      end
    endcase
    // Output flops follow the next state, so pins change with the state register.
    motor_d = (st_d == sgl_pkg::SGL_RUN);
    alarm_d = (st_d == sgl_pkg::SGL_TRIP);
  end

  // ----------------------------------------------------------------
  // Edit lock
  // ----------------------------------------------------------------
  logic grant_q;
  logic grant_d;
  logic refuse_q;
  logic refuse_d;
  logic locked;

  // Frequency edits pass under lock only when the scope leaves them open.
  always_comb
  begin
    locked = term.edit_lock_input && (!edit_is_freq || lock_scope_q);
    grant_d = edit_req && !locked;
    refuse_d = edit_req && locked;
  end

  // Controller and output registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= sgl_pkg::SGL_SETTLE;
      code_q <= sgl_pkg::NO_FAULT_CODE;
      settle_q <= '0;
      grant_q <= 1'b0;
      refuse_q <= 1'b0;
      motor_q <= 1'b0;
      alarm_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      code_q <= code_d;
      settle_q <= settle_d;
      grant_q <= grant_d;
      refuse_q <= refuse_d;
      motor_q <= motor_d;
      alarm_q <= alarm_d;
    end
  end

  assign motor_run = motor_q;
  assign alarm = alarm_q;
  assign fault_code = code_q;
  assign edit_grant = grant_q;
  assign edit_refuse = refuse_q;

endmodule

/* File: sgl_chk.sv */
// Checker for the start guard and edit lock port behaviour.
`timescale 1ns/10ps
module sgl_chk #(
  parameter int unsigned CLEAR_HOLD_CYC = 50
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic run_cmd_raw, // Run terminal.
  input wire logic start_guard_input_raw, // Guard terminal.
  input wire logic edit_lock_input_raw, // Lock terminal.
  input wire logic fault_clear_input_raw, // Clear terminal.
  input wire logic keypad_reset, // Keypad reset.
  input wire logic edit_req, // Edit request.
  input wire logic edit_is_freq, // Frequency edit.
  input wire logic edit_grant, // Edit granted.
  input wire logic edit_refuse, // Edit refused.
  input wire logic motor_run, // Motor drive.
  input wire logic alarm, // Alarm.
  input wire logic [7:0] fault_code // Fault code.
);
  logic [7:0] rh_q, rh_d, rl_q, rl_d, lh_q, lh_d, ll_q, ll_d;
  logic [31:0] fc_q, fc_d;
  function automatic logic [7:0] up(input logic on, input logic [7:0] c);
    return on ? ((c == 8'hff) ? c : c + 8'h01) : 8'h00;
  endfunction
  // Counts how long the run and lock levels, and a high fault clear level, have stood.
  always_comb
  begin
    rh_d = up(run_cmd_raw, rh_q);
    rl_d = up(!run_cmd_raw, rl_q);
    lh_d = up(edit_lock_input_raw, lh_q);
    ll_d = up(!edit_lock_input_raw, ll_q);
    fc_d = fault_clear_input_raw ? fc_q + 32'h1 : 32'h0;
  end
  // Registers the level counters.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rh_q <= 8'h0;
      rl_q <= 8'h0;
      lh_q <= 8'h0;
      ll_q <= 8'h0;
      fc_q <= 32'h0;
    end
    else
    begin
      rh_q <= rh_d;
      rl_q <= rl_d;
      lh_q <= lh_d;
      ll_q <= ll_d;
      fc_q <= fc_d;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  edit_answer_a: assert property (edit_req |=> edit_grant != edit_refuse)
    else $error("edit request got no single answer");
  lock_refuse_a: assert property (edit_req && !edit_is_freq && lh_q > 8'd20 |=> edit_refuse)
    else $error("edit under lock was not refused");
  unlock_grant_a: assert property (edit_req && ll_q > 8'd20 |=> edit_grant)
    else $error("edit without lock was not granted");
  trip_code_a: assert property (alarm |-> fault_code == 8'h0d && !motor_run)
    else $error("trip without code or with motor on");
  trip_cause_a: assert property ($rose(alarm) |-> start_guard_input_raw && rh_q > 8'd15)
    else $error("trip without guard and run");
  run_drop_a: assert property (rl_q == 8'd30 |-> !alarm && !motor_run)
    else $error("run removed but trip or motor stays");
  run_start_a: assert property (rh_q == 8'd45 && !alarm |-> motor_run)
    else $error("run held but motor off");
  motor_filter_a: assert property ($rose(motor_run) |-> rh_q > 8'd15)
    else $error("motor started on unfiltered run");
  key_clear_a: assert property (keypad_reset && alarm |-> ##[1:3] motor_run)
    else $error("keypad reset did not clear trip");
  hold_clear_a: assert property (fc_q == CLEAR_HOLD_CYC + 30 |-> !alarm)
    else $error("alarm stayed after held fault clear");
  cover property ($fell(alarm));
  cover property (edit_req ##1 edit_refuse);
  cover property ($rose(motor_run));
endmodule
bind sgl_start_guard_and_edit_lock sgl_chk #(.CLEAR_HOLD_CYC(CLEAR_HOLD_CYC)) sgl_chk_i (
  .pclk, .presetn, .run_cmd_raw, .start_guard_input_raw, .edit_lock_input_raw,
  .fault_clear_input_raw, .keypad_reset, .edit_req, .edit_is_freq, .edit_grant,
  .edit_refuse, .motor_run, .alarm, .fault_code);

/* File: sgl_ctl_model.sv */
// Controller model that drives the terminal levels.
`timescale 1ns/10ps
module sgl_ctl_model #(
  parameter int unsigned HOLD = 100
) (
  input wire logic pclk, // System clock.
  input wire sgl_pkg::sgl_term_s want, // Levels asked for by the bench.
  input wire logic fc_go, // Starts one fault clear pulse.
  output logic run_cmd_raw, // Run terminal.
  output logic start_guard_input_raw, // Guard terminal.
  output logic edit_lock_input_raw, // Lock terminal.
  output logic fault_clear_input_raw // Fault clear terminal.
);
  int unsigned hold_q = 0;
  int unsigned hold_d;
  // Keeps fault clear up long enough to be accepted.
  always_comb
  begin
    hold_d = fc_go ? HOLD : ((hold_q == 0) ? 0 : hold_q - 1);
  end
  // Terminals change just after the clock edge.
  always_ff @(posedge pclk)
  begin
    hold_q <= hold_d;
    run_cmd_raw <= want.run_cmd;
    start_guard_input_raw <= want.start_guard_input;
    edit_lock_input_raw <= want.edit_lock_input;
    fault_clear_input_raw <= (hold_d != 0);
  end
endmodule

/* File: sgl_tb.sv */
// Self-checking testbench for the start guard and edit lock block.
`timescale 1ns/10ps
module tb;
  localparam int unsigned HOLD = 50;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, fc_go;
  logic keypad_reset, edit_req, edit_is_freq, edit_grant, edit_refuse, motor_run, alarm;
  logic run_cmd_raw, start_guard_input_raw, edit_lock_input_raw, fault_clear_input_raw;
  logic [7:0] paddr, fault_code;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  sgl_pkg::sgl_term_s want;
  int error_cnt, comparisons;
  // Rows hold lock, scope, frequency edit and the expected refusal.
  logic [3:0] rows [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h9, 4'ha, 4'hd, 4'hf};
  sgl_start_guard_and_edit_lock #(.CLEAR_HOLD_CYC(HOLD), .STABLE_CYC(16))
  sgl_start_guard_and_edit_lock_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .run_cmd_raw, .start_guard_input_raw, .edit_lock_input_raw,
    .fault_clear_input_raw, .keypad_reset, .edit_req, .edit_is_freq, .edit_grant,
    .edit_refuse, .motor_run, .alarm, .fault_code);
  sgl_ctl_model #(.HOLD(100)) sgl_ctl_model_i (.pclk, .want, .fc_go, .run_cmd_raw,
    .start_guard_input_raw, .edit_lock_input_raw, .fault_clear_input_raw);
  // Makes the 100 MHz clock.
  initial
  begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("MISMATCH %s exp %h got %h", n, e, g);
      error_cnt++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer; the answer is taken at the edge that sees pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic pwr(input logic [3:0] t);
    presetn <= 1'h0;
    want <= t;
    cyc(3);
    presetn <= 1'h1;
    cyc(40);
  endtask
  task automatic outs(input string n, input logic m, input logic a, input logic [7:0] c);
    chk(n, {22'h0, m, a, c}, {22'h0, motor_run, alarm, fault_code});
    $display("test %s done", n);
  endtask
  // Main sequence.
  initial
  begin
    {presetn, psel, penable, pwrite, fc_go, keypad_reset, edit_req, edit_is_freq} = 8'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    want = 4'h0;
    cyc(3);
    presetn <= 1'h1;
    cyc(2);
    foreach (rows[i])
    begin
      want <= {1'h0, rows[i][3], 2'h0};
      apb(1'h1, 8'h00, {31'h0, rows[i][2]});
      cyc(25);
      edit_req <= 1'h1;
      edit_is_freq <= rows[i][1];
      @(posedge pclk);
      edit_req <= 1'h0;
      @(posedge pclk);
      chk("edit", {30'h0, ~rows[i][0], rows[i][0]}, {30'h0, edit_grant, edit_refuse});
    end
    $display("test edit table done");
    apb(1'h0, 8'h00, 32'h0);
    chk("scope", 32'h1, rd);
    pwr(4'h1);
    outs("plain start", 1'h1, 1'h0, 8'h00);
    apb(1'h0, 8'h00, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'h0, 8'h08, 32'h0);
    chk("func", 32'h0000_0f0d, rd);
    apb(1'h0, 8'h0c, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    pwr(4'h0);
    want <= 4'h1;
    cyc(5);
    want <= 4'h0;
    cyc(30);
    outs("glitch", 1'h0, 1'h0, 8'h00);
    pwr(4'h3);
    outs("guard trip", 1'h0, 1'h1, 8'h0d);
    apb(1'h0, 8'h04, 32'h0);
    chk("status", 32'h0000_0d36, rd);
    want <= 4'h2;
    cyc(30);
    outs("run drop", 1'h0, 1'h0, 8'h00);
    want <= 4'h3;
    cyc(30);
    outs("rerun", 1'h1, 1'h0, 8'h00);
    pwr(4'h2);
    want <= 4'h3;
    cyc(30);
    outs("late run", 1'h1, 1'h0, 8'h00);
    pwr(4'h3);
    fc_go <= 1'h1;
    @(posedge pclk);
    fc_go <= 1'h0;
    cyc(40);
    outs("early clear", 1'h0, 1'h1, 8'h0d);
    cyc(40);
    outs("pin clear", 1'h1, 1'h0, 8'h00);
    pwr(4'h3);
    keypad_reset <= 1'h1;
    @(posedge pclk);
    keypad_reset <= 1'h0;
    cyc(3);
    outs("keypad", 1'h1, 1'h0, 8'h00);
    pwr(4'h3);
    apb(1'h1, 8'h00, 32'h2);
    cyc(3);
    outs("soft reset", 1'h1, 1'h0, 8'h00);
    wrap_up();
  end
  // Cuts a hang short well after the tests should have ended.
  initial
  begin
    #100us;
    error_cnt++;
    wrap_up();
  end
endmodule
